// ### include/atd_pkg.sv
`default_nettype none
package atd_pkg;

  localparam int          ATD_IW       = 10;
  localparam int          ATD_DW       = 4;
  localparam int          ATD_NUM_DST  = 6;

  localparam logic [9:0]  ATD_OP_IRQ2  = 10'h03E;
  localparam logic [9:0]  ATD_OP_TMR1  = 10'h20E;
  localparam logic [9:0]  ATD_OP_TMR2  = 10'h20F;
  localparam logic [9:0]  ATD_OP_TMR5  = 10'h212;
  localparam logic [9:0]  ATD_OP_TMR6  = 10'h213;
  localparam logic [9:0]  ATD_OP_YPTR  = 10'h00C;

  localparam int          ATD_IX_IRQ2  = 0;
  localparam int          ATD_IX_TMR1  = 1;
  localparam int          ATD_IX_TMR2  = 2;
  localparam int          ATD_IX_TMR5  = 3;
  localparam int          ATD_IX_TMR6  = 4;
  localparam int          ATD_IX_YPTR  = 5;

  localparam logic [3:0]  ATD_RST_VAL  = 4'h0;
  localparam int          ATD_LOAD_LAT = 1;

  typedef logic [ATD_NUM_DST-1:0] atd_sel_t;

  function automatic atd_sel_t atd_match(input logic [9:0] word, input logic [9:0] op_tmr5);
    atd_sel_t sel;
    sel              = '0;
    sel[ATD_IX_IRQ2] = (word == ATD_OP_IRQ2);
    sel[ATD_IX_TMR1] = (word == ATD_OP_TMR1);
    sel[ATD_IX_TMR2] = (word == ATD_OP_TMR2);
    sel[ATD_IX_TMR5] = (word == op_tmr5);
    sel[ATD_IX_TMR6] = (word == ATD_OP_TMR6);
    sel[ATD_IX_YPTR] = (word == ATD_OP_YPTR);
    return sel;
  endfunction : atd_match

endpackage : atd_pkg
`default_nettype wire

// ### design/atd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module atd_decode
  import atd_pkg::*;
#(
  parameter logic [9:0] P_OP_TMR5 = ATD_OP_TMR5
) (
  // Instruction.
  input  wire logic [ATD_IW-1:0] instr_word,
  input  wire logic              instr_exec,
  // Decoded destination.
  output atd_sel_t               dst_sel,
  output logic                   xfer_hit
);

  // A word only selects a destination in the cycle it executes.
  always_comb begin
    dst_sel  = instr_exec ? atd_match(instr_word, P_OP_TMR5) : '0;
    xfer_hit = |dst_sel;
  end

endmodule : atd_decode
`default_nettype wire

// ### design/atd_top.sv
// Contract
// - Executing the accumulator-to-interrupt-control-2 transfer loads that register with the accumulator.
// - Word 1000001110 loads timer control register one from the accumulator in one cycle, no carry change, no skip.
// - Word 1000001111 loads timer control register two from the accumulator in one cycle, no carry change, no skip.
// - A dedicated word loads timer control register five from the accumulator in one cycle, no carry change, no skip.
// - A dedicated word loads timer control register six from the accumulator in one cycle, no carry change, no skip.
// - Word 0000001100 loads the Y pointer from the accumulator in one cycle, no carry change, no skip.
`timescale 1ns/1ps
`default_nettype none
module atd_top
  import atd_pkg::*;
#(
  parameter logic [9:0] P_OP_TMR5 = ATD_OP_TMR5
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Instruction path.
  input  wire logic [ATD_IW-1:0] instr_word,
  input  wire logic              instr_exec,
  input  wire logic [ATD_DW-1:0] acc_in,
  // Destination registers.
  output logic [ATD_DW-1:0]      irq_ctrl_reg2,
  output logic [ATD_DW-1:0]      tmr_ctrl_reg1,
  output logic [ATD_DW-1:0]      tmr_ctrl_reg2,
  output logic [ATD_DW-1:0]      tmr_ctrl_reg5,
  output logic [ATD_DW-1:0]      tmr_ctrl_reg6,
  output logic [ATD_DW-1:0]      y_pointer,
  // Core side effects.
  output logic                   xfer_claim,
  output logic                   acc_wr_en,
  output logic                   carry_flag_wr_en,
  output logic                   skip_next
);

  // The fifth timer opcode must not shadow any other transfer of the group.
  if (P_OP_TMR5 == ATD_OP_IRQ2 || P_OP_TMR5 == ATD_OP_TMR1 || P_OP_TMR5 == ATD_OP_TMR2 ||
      P_OP_TMR5 == ATD_OP_TMR6 || P_OP_TMR5 == ATD_OP_YPTR) begin : g_bad_op
    $error("P_OP_TMR5 collides with another transfer opcode");
  end

  // The decoder compares whole 10-bit words and every destination loads in a single cycle.
  if (ATD_IW != 10) begin : g_bad_iw
    $error("instruction width must be 10 bits");
  end

  if (ATD_LOAD_LAT != 1) begin : g_bad_lat
    $error("destinations can only load one cycle after the transfer");
  end

  if (ATD_NUM_DST != 6) begin : g_bad_num
    $error("the group has exactly six destinations");
  end

  atd_sel_t            dst_sel;
  logic                xfer_hit;
  logic [ATD_DW-1:0]   dst_r [ATD_NUM_DST];
  logic                xfer_claim_r;

  atd_decode #(
    .P_OP_TMR5  (P_OP_TMR5)
  ) u_decode (
    .instr_word (instr_word),
    .instr_exec (instr_exec),
    .dst_sel    (dst_sel),
    .xfer_hit   (xfer_hit)
  );

  // Each destination loads only when its own transfer executes, takes ATD_RST_VAL while rst is high, and holds otherwise.
  for (genvar i = 0; i < ATD_NUM_DST; i++) begin : g_dst
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        dst_r[i] <= ATD_RST_VAL;
      end else if (dst_sel[i]) begin
        dst_r[i] <= acc_in;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xfer_claim_r <= 1'b0;
    end else begin
      xfer_claim_r <= xfer_hit;
    end
  end

  assign irq_ctrl_reg2 = dst_r[ATD_IX_IRQ2];
  assign tmr_ctrl_reg1 = dst_r[ATD_IX_TMR1];
  assign tmr_ctrl_reg2 = dst_r[ATD_IX_TMR2];
  assign tmr_ctrl_reg5 = dst_r[ATD_IX_TMR5];
  assign tmr_ctrl_reg6 = dst_r[ATD_IX_TMR6];
  assign y_pointer     = dst_r[ATD_IX_YPTR];
  assign xfer_claim    = xfer_claim_r;

  // None of these transfers writes the accumulator, touches carry or requests a skip.
  assign acc_wr_en        = 1'b0;
  assign carry_flag_wr_en = 1'b0;
  assign skip_next        = 1'b0;

  // Checks.
  sequence s_exec_op(logic [9:0] op);
    instr_exec && instr_word == op;
  endsequence

  sequence s_no_exec;
    !xfer_hit;
  endsequence

  property p_load(logic [9:0] op, int ix);
    @(posedge clk_sys) disable iff (rst)
      s_exec_op(op) |=> (dst_r[ix] == $past(acc_in));
  endproperty

  a_irq2_load: assert property (p_load(ATD_OP_IRQ2, ATD_IX_IRQ2))
    else $error("interrupt control 2 did not take the accumulator");

  a_tmr1_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_exec_op(ATD_OP_TMR1) |=> tmr_ctrl_reg1 == $past(acc_in) && xfer_claim && !skip_next)
    else $error("timer control 1 transfer wrong");

  a_tmr2_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_exec_op(ATD_OP_TMR2) |=> tmr_ctrl_reg2 == $past(acc_in) && !carry_flag_wr_en)
    else $error("timer control 2 transfer wrong");

  a_tmr5_load: assert property (p_load(P_OP_TMR5, ATD_IX_TMR5))
    else $error("timer control 5 did not take the accumulator");

  a_tmr6_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_exec_op(ATD_OP_TMR6) |=> tmr_ctrl_reg6 == $past(acc_in) && xfer_claim)
    else $error("timer control 6 did not take the accumulator");

  a_ypnt_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_exec_op(ATD_OP_YPTR) ##1 s_no_exec |=> y_pointer == $past(acc_in, 2))
    else $error("Y pointer lost the transferred value");

  a_hold_idle: assert property (@(posedge clk_sys) disable iff (rst)
    s_no_exec |=> $stable(irq_ctrl_reg2) && $stable(tmr_ctrl_reg1) && $stable(tmr_ctrl_reg2)
      && $stable(tmr_ctrl_reg5) && $stable(tmr_ctrl_reg6) && $stable(y_pointer))
    else $error("a destination changed without its transfer");

  a_claim_once: assert property (@(posedge clk_sys) disable iff (rst)
    xfer_hit |=> xfer_claim && !acc_wr_en)
    else $error("transfer not claimed or accumulator written");

  a_only_target: assert property (@(posedge clk_sys) disable iff (rst)
    s_exec_op(ATD_OP_TMR1) |=> $stable(tmr_ctrl_reg2) && $stable(y_pointer) && $stable(irq_ctrl_reg2))
    else $error("timer control 1 transfer disturbed another register");

  // Idle cycles and refused words raise no claim and touch no side effect.
  a_claim_idle: assert property (@(posedge clk_sys) disable iff (rst)
    s_no_exec |=> !xfer_claim)
    else $error("claim raised without a transfer");

  a_claim_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    xfer_claim |-> $past(xfer_hit))
    else $error("claim not preceded by a transfer");

  a_exec_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !instr_exec |-> !xfer_hit)
    else $error("a word decoded while nothing executed");

  a_side_effects: assert property (@(posedge clk_sys) disable iff (rst)
    xfer_hit |-> !carry_flag_wr_en && !skip_next && !acc_wr_en)
    else $error("a transfer touched carry, skip or the accumulator");

  // A transfer loads only its own destination.
  property p_only(logic [9:0] op, int ix);
    @(posedge clk_sys) disable iff (rst)
      s_exec_op(op) |=> (ix == ATD_IX_IRQ2 || $stable(irq_ctrl_reg2)) && (ix == ATD_IX_TMR1 || $stable(tmr_ctrl_reg1))
        && (ix == ATD_IX_TMR2 || $stable(tmr_ctrl_reg2)) && (ix == ATD_IX_TMR5 || $stable(tmr_ctrl_reg5))
        && (ix == ATD_IX_TMR6 || $stable(tmr_ctrl_reg6)) && (ix == ATD_IX_YPTR || $stable(y_pointer));
  endproperty

  a_irq2_only: assert property (p_only(ATD_OP_IRQ2, ATD_IX_IRQ2))
    else $error("interrupt control 2 transfer disturbed another register");

  a_tmr2_only: assert property (p_only(ATD_OP_TMR2, ATD_IX_TMR2))
    else $error("timer control 2 transfer disturbed another register");

  a_tmr5_only: assert property (p_only(P_OP_TMR5, ATD_IX_TMR5))
    else $error("timer control 5 transfer disturbed another register");

  a_tmr6_only: assert property (p_only(ATD_OP_TMR6, ATD_IX_TMR6))
    else $error("timer control 6 transfer disturbed another register");

  a_ypnt_only: assert property (p_only(ATD_OP_YPTR, ATD_IX_YPTR))
    else $error("Y pointer transfer disturbed another register");

  // The loaded value survives a following idle cycle.
  property p_hold(logic [9:0] op, int ix);
    @(posedge clk_sys) disable iff (rst)
      s_exec_op(op) ##1 s_no_exec |=> dst_r[ix] == $past(acc_in, 2);
  endproperty

  a_irq2_hold: assert property (p_hold(ATD_OP_IRQ2, ATD_IX_IRQ2))
    else $error("interrupt control 2 lost the transferred value");

  a_tmr1_hold: assert property (p_hold(ATD_OP_TMR1, ATD_IX_TMR1))
    else $error("timer control 1 lost the transferred value");

  a_tmr2_hold: assert property (p_hold(ATD_OP_TMR2, ATD_IX_TMR2))
    else $error("timer control 2 lost the transferred value");

  a_tmr5_hold: assert property (p_hold(P_OP_TMR5, ATD_IX_TMR5))
    else $error("timer control 5 lost the transferred value");

  a_tmr6_hold: assert property (p_hold(ATD_OP_TMR6, ATD_IX_TMR6))
    else $error("timer control 6 lost the transferred value");

  // Back-to-back transfers must both land.
  sequence s_pair_tmr12;
    s_exec_op(ATD_OP_TMR1) ##1 s_exec_op(ATD_OP_TMR2);
  endsequence

  sequence s_pair_tmr6_y;
    s_exec_op(ATD_OP_TMR6) ##1 s_exec_op(ATD_OP_YPTR);
  endsequence

  a_pair_tmr12: assert property (@(posedge clk_sys) disable iff (rst)
    s_pair_tmr12 |=> tmr_ctrl_reg1 == $past(acc_in, 2) && tmr_ctrl_reg2 == $past(acc_in))
    else $error("back to back timer transfers lost a value");

  a_pair_tmr6_y: assert property (@(posedge clk_sys) disable iff (rst)
    s_pair_tmr6_y |=> tmr_ctrl_reg6 == $past(acc_in, 2) && y_pointer == $past(acc_in))
    else $error("back to back timer and Y pointer transfers lost a value");

endmodule : atd_top
`default_nettype wire

// ### sim/atd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module atd_fetch_model
  import atd_pkg::*;
(
  // Clock and requests.
  input  wire logic              clk_sys,
  input  wire logic              req_exec,
  input  wire logic [ATD_IW-1:0] req_word,
  // Fetch path.
  output logic [ATD_IW-1:0]      instr_word,
  output logic                   instr_exec
);
  logic [ATD_IW-1:0] last_r = '0;
  // An idle fetch path shows a word that changes every cycle, updated just after the sampling edge.
  always @(posedge clk_sys) begin
    last_r <= instr_word;
  end
  assign instr_exec = req_exec;
  assign instr_word = req_exec ? req_word : ~last_r;
endmodule : atd_fetch_model
`default_nettype wire

// ### sim/test_accumulator_transfer_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_accumulator_transfer_decode;
  import atd_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       req_exec = 1'b0;
  logic [9:0] req_word = '0;
  logic [3:0] acc_in = '0;
  logic [9:0] instr_word;
  logic       instr_exec, xfer_claim, acc_wr_en, carry_flag_wr_en, skip_next;
  logic [3:0] r [6];
  logic [3:0] exp_r [6];
  logic [9:0] ops [6] = '{10'h03E, 10'h20E, 10'h20F, 10'h212, 10'h213, 10'h00C};
  int         error_cnt = 0, checked = 0, seed = 32'haf693e83, hit;
  always #12.5 clk_sys = ~clk_sys;
  atd_fetch_model fm (.clk_sys(clk_sys), .req_exec(req_exec), .req_word(req_word), .instr_word(instr_word),
    .instr_exec(instr_exec));
  atd_top uut (.clk_sys(clk_sys), .rst(rst), .instr_word(instr_word), .instr_exec(instr_exec), .acc_in(acc_in),
    .irq_ctrl_reg2(r[0]), .tmr_ctrl_reg1(r[1]), .tmr_ctrl_reg2(r[2]), .tmr_ctrl_reg5(r[3]),
    .tmr_ctrl_reg6(r[4]), .y_pointer(r[5]), .xfer_claim(xfer_claim), .acc_wr_en(acc_wr_en),
    .carry_flag_wr_en(carry_flag_wr_en), .skip_next(skip_next));
  function automatic int find_op(input logic [9:0] w);
    find_op = -1;
    for (int i = 0; i < 6; i++) if (ops[i] === w) find_op = i;
  endfunction : find_op
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test;
    $display("Counts: checked=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic step(input logic e, input logic [9:0] w, input logic [3:0] a);
    req_exec = e;
    req_word = w;
    acc_in = a;
    hit = (e && !rst) ? find_op(w) : -1;
    @(negedge clk_sys);
    if (hit >= 0) exp_r[hit] = a;
    check(r[0], exp_r[0]);
    check(r[1], exp_r[1]);
    check(r[2], exp_r[2]);
    check(r[3], exp_r[3]);
    check(r[4], exp_r[4]);
    check(r[5], exp_r[5]);
    check({3'h0, xfer_claim}, {3'h0, hit >= 0});
    check({1'b0, acc_wr_en, carry_flag_wr_en, skip_next}, 4'h0);
  endtask : step
  initial begin
    for (int i = 0; i < 6; i++) exp_r[i] = 4'h0;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    step(1'b0, 10'h20E, 4'h5);
    $display("Test reset values done");
    for (int i = 0; i < 6; i++) step(1'b1, ops[i], 4'hF - 4'(i));
    for (int i = 0; i < 6; i++) step(1'b0, ops[i], 4'h3);
    step(1'b1, 10'h03F, 4'hA);
    step(1'b1, 10'h20C, 4'hA);
    $display("Test opcodes and near misses done");
    rst = 1'b1;
    for (int i = 0; i < 6; i++) exp_r[i] = ATD_RST_VAL;
    step(1'b1, ops[1], 4'h9);
    step(1'b0, ops[2], 4'h9);
    rst = 1'b0;
    step(1'b1, ops[5], 4'h6);
    $display("Test reset in mid-run done");
    for (int n = 0; n < 400; n++)
      step($random(seed) % 4 != 0, ($random(seed) & 1) ? ops[$unsigned($random(seed)) % 6] : 10'($random(seed)),
        4'($random(seed)));
    $display("Test random stream done");
    finish_test();
  end
  initial begin
    #25000;
    error_cnt++;
    finish_test();
  end
endmodule : test_accumulator_transfer_decode
`default_nettype wire
